// *** sram_pkg.sv ***
package sram_pkg;
  localparam int LANE_W = 9;
  localparam int DEF_WORD_W = 18;
  localparam int DEF_ADDR_W = 21;
  localparam int WB_ADR_W = 8;

  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] RD_CNT_OFF = 8'h08;
  localparam logic [7:0] WR_CNT_OFF = 8'h0c;

  localparam int CTRL_RD_EN_BIT = 0;
  localparam int CTRL_WR_EN_BIT = 1;
  localparam int STATUS_DLL_ON_BIT = 0;
  localparam int STATUS_SINGLE_BIT = 1;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
  } ctrl_t;

  typedef struct packed {
    logic single_clock;
    logic dll_on;
  } status_t;

  localparam ctrl_t CTRL_RESET = 2'h3;
  localparam status_t STATUS_RESET = 2'h1;
  localparam logic [2:0] PIN_RESET = 3'h4;
endpackage

// *** level_sync.sv ***
`timescale 1ns/10ps
module level_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;
  logic [W-1:0] agree;

  // a bit only moves once the second and third stage agree
  always_comb begin
    agree = ~(s2_reg ^ s3_reg);
    q_next = (agree & s3_reg) | (~agree & q_reg);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule

// *** event_sync.sv ***
`timescale 1ns/10ps
module event_sync (
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic src_pulse,
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic dst_pulse
);
  logic tog_reg;
  logic tog_next;
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic pulse_reg;
  logic pulse_next;

  // toggle form: destination must be faster than one event per src cycle
  always_comb begin
    tog_next = src_rst_n ? (tog_reg ^ src_pulse) : 1'b0;
    pulse_next = dst_rst_n ? (s2_reg ^ s3_reg) : 1'b0;
  end

  always_ff @(posedge src_clk) begin
    tog_reg <= tog_next;
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= tog_reg;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
    pulse_reg <= pulse_next;
  end

  assign dst_pulse = pulse_reg;
endmodule

// *** ddr_burst_sram.sv ***
`timescale 1ns/10ps
module ddr_burst_sram #(
  parameter int ADDR_W = sram_pkg::DEF_ADDR_W,
  parameter int WORD_W = sram_pkg::DEF_WORD_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sram_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic k_clk,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [WORD_W-1:0] d,
  input wire logic [WORD_W/sram_pkg::LANE_W-1:0] byte_write_select_n,
  input wire logic dll_disable_n,
  input wire logic c_strap,
  input wire logic cb_strap,
  output logic [WORD_W-1:0] q_rise,
  output logic q_rise_oe,
  output logic [WORD_W-1:0] q_fall,
  output logic q_fall_oe
);
  localparam int LANES = WORD_W / sram_pkg::LANE_W;
  localparam int LW = sram_pkg::LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // two halves of each location: word a+0 and word a+1
  logic [WORD_W-1:0] mem_lo [DEPTH];
  logic [WORD_W-1:0] mem_hi [DEPTH];
  // not reset: a word never written reads back unknown

  logic link_rst_n;
  sram_pkg::ctrl_t ctrl_reg;
  sram_pkg::ctrl_t ctrl_next;
  sram_pkg::ctrl_t k_ctrl;
  logic [2:0] pin_q;
  logic dll_on;
  sram_pkg::status_t k_status;
  sram_pkg::status_t ref_status;
  logic rd_evt;
  logic wr_evt;

  // link side reset follows the bus reset through the link clock
  level_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .clk(k_clk),
    .rst_n(1'b1),
    .d(rst_n),
    .q(link_rst_n)
  );

  level_sync #(.W(2), .RST_VAL(sram_pkg::CTRL_RESET)) u_ctrl_sync (
    .clk(k_clk),
    .rst_n(link_rst_n),
    .d(ctrl_reg),
    .q(k_ctrl)
  );

  // pin sync runs free: held in reset it would hide the strap during
  // the very window in which the strap is latched
  level_sync #(.W(3), .RST_VAL(sram_pkg::PIN_RESET)) u_pin_sync (
    .clk(k_clk),
    .rst_n(1'b1),
    .d({dll_disable_n, c_strap, cb_strap}),
    .q(pin_q)
  );

  // changing the dll pin in the middle of a read may tear that read
  assign dll_on = pin_q[2];

  // status bits are quasi-static, so a per-bit level sync is enough
  level_sync #(.W(2), .RST_VAL(sram_pkg::STATUS_RESET)) u_stat_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(k_status),
    .q(ref_status)
  );

  // link: k rising edge
  logic rd_valid_reg, rd_valid_next;
  logic [ADDR_W-1:0] rd_addr_reg, rd_addr_next;
  logic stage_valid_reg, stage_valid_next;
  logic [WORD_W-1:0] rd0_reg, rd0_next;
  logic [WORD_W-1:0] rd1_reg, rd1_next;
  logic w_pend_reg, w_pend_next;
  logic [WORD_W-1:0] d0_reg, d0_next;
  logic [LANES-1:0] be0_reg, be0_next;
  logic [WORD_W-1:0] q_rise_reg, q_rise_next;
  logic q_rise_oe_reg, q_rise_oe_next;
  logic single_reg, single_next;

  // link: k-bar rising edge
  logic cm_valid_reg, cm_valid_next;
  logic [ADDR_W-1:0] cm_addr_reg, cm_addr_next;
  logic [WORD_W-1:0] cm_d0_reg, cm_d0_next;
  logic [WORD_W-1:0] cm_d1_reg, cm_d1_next;
  logic [LANES-1:0] cm_be0_reg, cm_be0_next;
  logic [LANES-1:0] cm_be1_reg, cm_be1_next;
  logic [WORD_W-1:0] q_fall_reg, q_fall_next;
  logic q_fall_oe_reg, q_fall_oe_next;

  logic [WORD_W-1:0] old_lo, old_hi;
  logic [WORD_W-1:0] merged_lo, merged_hi;
  logic [WORD_W-1:0] word0_now, word1_now;
  logic fwd_hit;

  assign old_lo = mem_lo[cm_addr_reg];
  assign old_hi = mem_hi[cm_addr_reg];

  // lanes with select high keep stored data
  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      assign merged_lo[gl*LW +: LW] = cm_be0_reg[gl] ?
        old_lo[gl*LW +: LW] : cm_d0_reg[gl*LW +: LW];
      assign merged_hi[gl*LW +: LW] = cm_be1_reg[gl] ?
        old_hi[gl*LW +: LW] : cm_d1_reg[gl*LW +: LW];
    end
  endgenerate

  // a write committing on this edge is forwarded to a read of its address
  // so a read taken on the same k rise as that write sees the new data
  always_comb begin
    fwd_hit = cm_valid_reg && (cm_addr_reg == rd_addr_reg);
    word0_now = fwd_hit ? merged_lo : mem_lo[rd_addr_reg];
    word1_now = fwd_hit ? merged_hi : mem_hi[rd_addr_reg];
  end

  always_comb begin
    // port selects only count on k rise
    rd_valid_next = ~read_port_select_n & k_ctrl.rd_en;
    rd_addr_next = addr;
    w_pend_next = ~write_port_select_n & k_ctrl.wr_en;
    d0_next = d;
    be0_next = byte_write_select_n;
    stage_valid_next = rd_valid_reg;
    rd0_next = word0_now;
    rd1_next = word1_now;
    single_next = single_reg;
    q_rise_next = q_rise_reg;
    q_rise_oe_next = 1'b0;
    if (dll_on) begin
      // second word on the k rise after the k-bar launch
      if (stage_valid_reg) begin
        q_rise_next = rd1_reg;
        q_rise_oe_next = 1'b1;
      end
    end else if (rd_valid_reg) begin
      // first word one cycle after the request
      q_rise_next = word0_now;
      q_rise_oe_next = 1'b1;
    end
    if (!link_rst_n) begin
      rd_valid_next = 1'b0;
      w_pend_next = 1'b0;
      stage_valid_next = 1'b0;
      q_rise_oe_next = 1'b0;
      q_rise_next = '0;
      // strap is caught only while held in reset
      single_next = pin_q[1] & pin_q[0];
    end
  end

  always_ff @(posedge k_clk) begin
    rd_valid_reg <= rd_valid_next;
    rd_addr_reg <= rd_addr_next;
    stage_valid_reg <= stage_valid_next;
    rd0_reg <= rd0_next;
    rd1_reg <= rd1_next;
    w_pend_reg <= w_pend_next;
    d0_reg <= d0_next;
    be0_reg <= be0_next;
    q_rise_reg <= q_rise_next;
    q_rise_oe_reg <= q_rise_oe_next;
    single_reg <= single_next;
  end

  // both halves of a burst land in one array write
  always_ff @(posedge k_clk) begin
    if (cm_valid_reg) begin
      mem_lo[cm_addr_reg] <= merged_lo;
      mem_hi[cm_addr_reg] <= merged_hi;
    end
  end

  always_comb begin
    cm_valid_next = w_pend_reg & link_rst_n;
    cm_addr_next = addr;
    cm_d0_next = d0_reg;
    cm_d1_next = d;
    cm_be0_next = be0_reg;
    cm_be1_next = byte_write_select_n;
    // dll on: first word at k-bar; dll off: second word
    q_fall_next = dll_on ? rd0_reg : rd1_reg;
    q_fall_oe_next = stage_valid_reg & link_rst_n;
    if (!stage_valid_reg) begin
      q_fall_next = q_fall_reg;
    end
    if (!link_rst_n) begin
      q_fall_next = '0;
    end
  end

  always_ff @(negedge k_clk) begin
    cm_valid_reg <= cm_valid_next;
    cm_addr_reg <= cm_addr_next;
    cm_d0_reg <= cm_d0_next;
    cm_d1_reg <= cm_d1_next;
    cm_be0_reg <= cm_be0_next;
    cm_be1_reg <= cm_be1_next;
    q_fall_reg <= q_fall_next;
    q_fall_oe_reg <= q_fall_oe_next;
  end

  assign k_status = '{
    single_clock: single_reg,
    dll_on: dll_on
  };

  assign q_rise = q_rise_reg;
  assign q_rise_oe = q_rise_oe_reg;
  assign q_fall = q_fall_reg;
  assign q_fall_oe = q_fall_oe_reg;

  event_sync u_rd_evt (
    .src_clk(k_clk),
    .src_rst_n(link_rst_n),
    .src_pulse(rd_valid_reg),
    .dst_clk(ref_clk),
    .dst_rst_n(rst_n),
    .dst_pulse(rd_evt)
  );

  event_sync u_wr_evt (
    .src_clk(k_clk),
    .src_rst_n(link_rst_n),
    .src_pulse(cm_valid_reg),
    .dst_clk(ref_clk),
    .dst_rst_n(rst_n),
    .dst_pulse(wr_evt)
  );

  // wishbone slave
  // registered ack costs one wait state but keeps ack off the address path
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic [31:0] rd_cnt_reg, rd_cnt_next;
  logic [31:0] wr_cnt_reg, wr_cnt_next;
  logic [7:0] off;

  assign off = wb_adr_i[7:0];

  always_comb begin
    ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
    dat_next = dat_reg;
    ctrl_next = ctrl_reg;
    rd_cnt_next = rd_cnt_reg + {31'h0000_0000, rd_evt};
    wr_cnt_next = wr_cnt_reg + {31'h0000_0000, wr_evt};
    if (ack_next) begin
      dat_next = 32'h0000_0000;
      case (off)
        sram_pkg::CTRL_OFF: begin
          dat_next[1:0] = ctrl_reg;
          if (wb_we_i && wb_sel_i[0]) begin
            ctrl_next = wb_dat_i[1:0];
          end
        end
        sram_pkg::STATUS_OFF: begin
          dat_next[1:0] = ref_status;
        end
        sram_pkg::RD_CNT_OFF: begin
          dat_next = rd_cnt_reg;
        end
        sram_pkg::WR_CNT_OFF: begin
          dat_next = wr_cnt_reg;
        end
        default: begin
          dat_next = 32'h0000_0000;
        end
      endcase
    end
    if (!rst_n) begin
      ack_next = 1'b0;
      dat_next = 32'h0000_0000;
      ctrl_next = sram_pkg::CTRL_RESET;
      rd_cnt_next = 32'h0000_0000;
      wr_cnt_next = 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    ack_reg <= ack_next;
    dat_reg <= dat_next;
    ctrl_reg <= ctrl_next;
    rd_cnt_reg <= rd_cnt_next;
    wr_cnt_reg <= wr_cnt_next;
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
endmodule

// *** ctrl_model.sv ***
`timescale 1ns/10ps
module ctrl_model #(
  parameter int AW = 6,
  parameter int WW = 18
) (
  input wire logic k_clk,
  output logic read_port_select_n,
  output logic write_port_select_n,
  output logic [AW-1:0] addr,
  output logic [WW-1:0] d,
  output logic [WW/9-1:0] byte_write_select_n
);
  initial begin
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    addr = '0;
    d = '0;
    byte_write_select_n = '1;
  end
  // idle lines flip instead of holding, so stale values never match
  task automatic op(input logic rd, wr, input logic [AW-1:0] ra, wa,
    input logic [WW-1:0] d0, d1, input logic [WW/9-1:0] b0, b1);
    @(negedge k_clk);
    read_port_select_n <= ~rd;
    write_port_select_n <= ~wr;
    addr <= rd ? ra : ~addr;
    d <= wr ? d0 : ~d;
    byte_write_select_n <= wr ? b0 : ~byte_write_select_n;
    @(posedge k_clk);
    addr <= wr ? wa : ~addr;
    d <= wr ? d1 : ~d;
    byte_write_select_n <= wr ? b1 : ~byte_write_select_n;
  endtask
endmodule

// *** ddr_burst_sram_asserts.sv ***
`timescale 1ns/10ps
module ddr_burst_sram_asserts (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic k_clk,
  input wire logic read_port_select_n,
  input wire logic dll_disable_n,
  input wire logic q_rise_oe,
  input wire logic q_fall_oe
);
  sequence rd_on;
    !read_port_select_n && dll_disable_n;
  endsequence
  sequence rd_off;
    !read_port_select_n && !dll_disable_n;
  endsequence
  sequence rd_idle3;
    read_port_select_n [*3];
  endsequence
  a_rd_lat_on: assert property (@(posedge k_clk) disable iff (!rst_n)
    rd_on |-> ##3 q_rise_oe) else $error("late second beat, dll on");
  a_rd_no_early: assert property (@(posedge k_clk) disable iff (!rst_n)
    (rd_on ##0 $past(read_port_select_n)) |-> ##2 !q_rise_oe)
    else $error("rise beat too early, dll on");
  a_rd_lat_off: assert property (@(posedge k_clk) disable iff (!rst_n)
    rd_off |-> ##2 q_rise_oe) else $error("late first beat, dll off");
  a_fall_beat: assert property (@(posedge k_clk) disable iff (!rst_n)
    !read_port_select_n |-> ##2 q_fall_oe) else $error("no fall beat");
  a_idle_float: assert property (@(posedge k_clk) disable iff (!rst_n)
    rd_idle3 |=> !q_rise_oe && !q_fall_oe) else $error("outputs not floated");
  a_wb_ack_next: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("no ack");
  a_wb_ack_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_wb_no_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without cycle");
endmodule
bind ddr_burst_sram ddr_burst_sram_asserts u_chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .k_clk(k_clk), .q_rise_oe(q_rise_oe),
  .read_port_select_n(read_port_select_n), .q_fall_oe(q_fall_oe),
  .dll_disable_n(dll_disable_n));

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
  localparam int AW = 6;
  localparam int WW = 18;
  localparam int LN = WW / sram_pkg::LANE_W;
  logic ref_clk = 1'b0;
  logic k_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic rsel_n, wsel_n, rise_oe, fall_oe;
  logic [AW-1:0] addr;
  logic [WW-1:0] d, q_rise, q_fall;
  logic [LN-1:0] bsel_n;
  logic dll_disable_n = 1'b1;
  logic strap = 1'b0;
  int fails = 0;
  int total_checks = 0;
  int wcnt = 0;
  int rcnt = 0;
  logic wr_on = 1'b1;
  logic [15:0] lfsr = 16'h0036;
  logic [WW-1:0] mem [logic [AW:0]];
  logic [WW-1:0] expq [$];
  initial forever #4 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #15 k_clk = ~k_clk; // 33 MHz stays under the dll-off limit
  end
  ddr_burst_sram #(.ADDR_W(AW), .WORD_W(WW)) DUT (.ref_clk(ref_clk),
    .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .k_clk(k_clk), .read_port_select_n(rsel_n),
    .write_port_select_n(wsel_n), .addr(addr), .d(d),
    .byte_write_select_n(bsel_n), .dll_disable_n(dll_disable_n),
    .c_strap(strap), .cb_strap(strap), .q_rise(q_rise),
    .q_rise_oe(rise_oe), .q_fall(q_fall), .q_fall_oe(fall_oe));
  ctrl_model #(.AW(AW), .WW(WW)) u_ctrl (.k_clk(k_clk),
    .read_port_select_n(rsel_n), .write_port_select_n(wsel_n),
    .addr(addr), .d(d), .byte_write_select_n(bsel_n));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] v, logic [31:0] e);
    int n;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      fails++;
      close_out();
    end else if (!w) begin
      check("register", rdat, e);
    end
  endtask
  // a read taken on the same k rise as a write to its address sees new data
  task automatic xfer(logic rd, wr, logic [AW-1:0] ra, wa,
    logic [LN-1:0] b0, b1);
    logic [WW-1:0] dw [2];
    logic [LN-1:0] bw [2];
    dw[0] = WW'({rnd(), rnd()});
    dw[1] = WW'({rnd(), rnd()});
    bw[0] = b0;
    bw[1] = b1;
    for (int j = 0; wr && wr_on && j < 2; j++)
      for (int i = 0; i < LN; i++)
        if (!bw[j][i]) mem[{wa, j[0]}][i*9 +: 9] = dw[j][i*9 +: 9];
    if (rd) expq.push_back(mem[{ra, 1'b0}]);
    if (rd) expq.push_back(mem[{ra, 1'b1}]);
    wcnt += int'(wr & wr_on);
    rcnt += int'(rd);
    u_ctrl.op(rd, wr, ra, wa, dw[0], dw[1], b0, b1);
  endtask
  task automatic take(logic [WW-1:0] q);
    if (expq.size() == 0) check("spare beat", 32'(q), 32'h0000_0000);
    else check("read word", 32'(q), 32'(expq.pop_front()));
  endtask
  always @(posedge k_clk) begin
    #1;
    if (rise_oe === 1'b1) take(q_rise);
  end
  always @(negedge k_clk) begin
    #1;
    if (fall_oe === 1'b1) take(q_fall);
  end
  task automatic do_reset(logic dll, logic st);
    wcnt = 0;
    rcnt = 0;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    dll_disable_n <= dll;
    strap <= st;
    repeat (10) @(posedge k_clk);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge k_clk);
  endtask
  initial begin
    logic [15:0] r;
    int n;
    do_reset(1'b1, 1'b0);
    wb(1'b0, sram_pkg::CTRL_OFF, 0, 32'(sram_pkg::CTRL_RESET));
    wb(1'b0, sram_pkg::STATUS_OFF, 0, 32'(sram_pkg::STATUS_RESET));
    wb(1'b1, 8'h10, 32'h0000_0003, 0);
    wb(1'b0, 8'h10, 0, 32'h0000_0000);
    wb(1'b1, sram_pkg::CTRL_OFF, 32'h0000_0003, 0);
    for (int i = 0; i < 8; i++) xfer(0, 1, 0, i, '0, '0);
    for (int i = 0; i < 8; i++) xfer(1, 0, i, 0, '0, '0);
    xfer(0, 1, 0, 3, 2'b01, 2'b10);
    xfer(1, 1, 3, 5, '0, '0);
    xfer(1, 1, 5, 5, 2'b10, '0);
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      xfer(r[3], r[4], r[2:0], r[7:5], r[9:8], r[11:10]);
    end
    xfer(0, 0, 0, 0, '1, '1);
    wb(1'b1, sram_pkg::CTRL_OFF, 32'h0000_0001, 0);
    repeat (6) @(posedge k_clk);
    wr_on = 1'b0;
    xfer(0, 1, 0, 6, '0, '0); // write port disabled: location 6 kept
    xfer(1, 0, 6, 0, '0, '0);
    xfer(0, 0, 0, 0, '1, '1);
    wr_on = 1'b1;
    wb(1'b1, sram_pkg::CTRL_OFF, 32'h0000_0003, 0);
    repeat (6) @(posedge k_clk);
    repeat (4) xfer(0, 0, 0, 0, '1, '1);
    repeat (20) @(posedge ref_clk);
    wb(1'b0, sram_pkg::WR_CNT_OFF, 0, 32'(wcnt));
    wb(1'b0, sram_pkg::RD_CNT_OFF, 0, 32'(rcnt));
    do_reset(1'b0, 1'b1);
    wb(1'b0, sram_pkg::STATUS_OFF, 0, 32'h0000_0002);
    for (int i = 0; i < 8; i++) xfer(1, i[0], 7 - i, i, '0, '0);
    repeat (4) xfer(0, 0, 0, 0, '1, '1);
    n = 0;
    while (expq.size() != 0 && n < 20) begin
      @(posedge k_clk);
      n++;
    end
    if (expq.size() != 0) fails++;
    repeat (20) @(posedge ref_clk);
    wb(1'b0, sram_pkg::RD_CNT_OFF, 0, 32'(rcnt));
    wb(1'b0, sram_pkg::WR_CNT_OFF, 0, 32'(wcnt));
    close_out();
  end
endmodule
